// >>> hdl/pcrb_bank.sv
// Paged configuration register bank behind the serial configuration port.
// Assumes a controller on cs_n/sclk/sdi/sdo sending 24-bit frames.
`timescale 1ns/10ps
//Contract
// - Bank select low byte 0, 2, 16 routes access to bank 0, 1, 2.
// - Offset 06h reads back the whole control register and ignores writes.
// - Control register is write-only; reading its own offset yields nothing.
// - After reset the readback copy reads 2h, read-enable bit set.
// - Control bit 1 enables reads in legacy mode; ignored in daisy-chain mode.
// - Read frame FE,00,address; next frame returns address then 16-bit data.
module pcrb_bank (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	output logic sdo,
	output logic legacy_mode,
	output logic read_enable,
	output logic [7:0] bank_code,
	output logic [3:0] init_key
);
	pcrb_link_if link ();

	logic [15:0] ctrl_q;
	logic [15:0] bank_q;
	logic [15:0] key_q;
	logic [15:0] b1_q [pcrb_pkg::B1_COUNT];
	logic [15:0] tail_f6_q;
	logic [15:0] tail_fb_q;
	logic swrst_q;
	logic load_q;
	logic [23:0] load_word_q;
	logic [pcrb_pkg::B1_COUNT-1:0] b1_hit;
	logic [7:0] lead;
	logic [7:0] addr_w;
	logic [15:0] data_w;
	logic [7:0] addr_r;
	logic is_read;
	logic is_write;
	logic in_bank0;
	logic in_bank1;
	logic read_ok;
	logic [15:0] rdata;

	pcrb_shifter u_shifter (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.cs_n(cs_n),
		.sclk(sclk),
		.sdi(sdi),
		.sdo(sdo),
		.link(link)
	);

	// Frame split: lead byte, then two bytes
	assign lead = link.frame_word[23:16];
	assign addr_w = link.frame_word[23:16];
	assign data_w = link.frame_word[15:0];
	assign addr_r = link.frame_word[7:0];
	assign is_read = link.frame_done && (lead == pcrb_pkg::CMD_READ);
	assign is_write = link.frame_done && (lead != pcrb_pkg::CMD_READ) &&
		(lead != pcrb_pkg::CMD_NOP);

	// Unknown codes select no bank at all
	assign in_bank0 = bank_q[7:0] == pcrb_pkg::BANK0_CODE;
	assign in_bank1 = bank_q[7:0] == pcrb_pkg::BANK1_CODE;

	// Daisy-chain mode reads regardless of the enable bit
	assign read_ok = ctrl_q[pcrb_pkg::CTRL_MODE_BIT] ?
		ctrl_q[pcrb_pkg::CTRL_RDEN_BIT] : 1'b1;

	genvar gi;
	generate
		for (gi = 0; gi < pcrb_pkg::B1_COUNT; gi++) begin : g_b1
			assign b1_hit[gi] = in_bank1 && (addr_w == pcrb_pkg::B1_OFFS[gi]);
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					b1_q[gi] <= pcrb_pkg::B1_RESET[gi];
				end else if (swrst_q) begin
					b1_q[gi] <= pcrb_pkg::B1_RESET[gi];
				end else if (is_write && b1_hit[gi]) begin
					b1_q[gi] <= data_w;
				end
			end
		end
	endgenerate

	// Bank 1 tail entries
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			tail_f6_q <= pcrb_pkg::B1_RESET_TAIL;
			tail_fb_q <= pcrb_pkg::B1_RESET_TAIL;
		end else if (swrst_q) begin
			tail_f6_q <= pcrb_pkg::B1_RESET_TAIL;
			tail_fb_q <= pcrb_pkg::B1_RESET_TAIL;
		end else if (is_write && in_bank1) begin
			if (addr_w == pcrb_pkg::B1_OFF_F6) begin
				tail_f6_q <= data_w;
			end
			if (addr_w == pcrb_pkg::B1_OFF_FB) begin
				tail_fb_q <= data_w;
			end
		end
	end

	// Control register; reset value has the read enable set
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= pcrb_pkg::CTRL_RESET;
		end else if (swrst_q) begin
			ctrl_q <= pcrb_pkg::CTRL_RESET;
		end else if (is_write && addr_w == pcrb_pkg::ADDR_CTRL &&
			!data_w[pcrb_pkg::CTRL_RST_BIT]) begin
			// A reset write is not stored, so mode bits do not blip before the reset
			ctrl_q <= data_w;
		end
	end

	// Soft reset pulse one cycle after the write
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			swrst_q <= 1'b0;
		end else begin
			swrst_q <= is_write && addr_w == pcrb_pkg::ADDR_CTRL &&
				data_w[pcrb_pkg::CTRL_RST_BIT];
		end
	end

	// Bank select reachable from any bank, else a bank could not be left
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_q <= pcrb_pkg::BANK_RESET;
		end else if (swrst_q) begin
			bank_q <= pcrb_pkg::BANK_RESET;
		end else if (is_write && addr_w == pcrb_pkg::ADDR_BANK) begin
			bank_q <= data_w;
		end
	end

	// Start-up key stored as written; sequencing is the controller's job
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			key_q <= pcrb_pkg::KEY_RESET;
		end else if (swrst_q) begin
			key_q <= pcrb_pkg::KEY_RESET;
		end else if (is_write && in_bank0 && addr_w == pcrb_pkg::ADDR_KEY) begin
			key_q <= data_w;
		end
	end

	// Read data for the requested offset in the selected bank
	always_comb begin
		rdata = 16'h0000;
		if (addr_r == pcrb_pkg::ADDR_BANK) begin
			rdata = bank_q;
		end else if (in_bank0) begin
			case (addr_r)
				pcrb_pkg::ADDR_KEY: rdata = key_q;
				pcrb_pkg::ADDR_COPY: rdata = ctrl_q;
				default: rdata = 16'h0000;
			endcase
		end else if (in_bank1) begin
			for (int i = 0; i < pcrb_pkg::B1_COUNT; i++) begin
				if (addr_r == pcrb_pkg::B1_OFFS[i]) begin
					rdata = b1_q[i];
				end
			end
			if (addr_r == pcrb_pkg::B1_OFF_F6) begin
				rdata = tail_f6_q;
			end
			if (addr_r == pcrb_pkg::B1_OFF_FB) begin
				rdata = tail_fb_q;
			end
		end
	end

	// Answer loaded at frame end, shifted out in the next frame
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			load_q <= 1'b0;
			load_word_q <= 24'h00_0000;
		end else begin
			load_q <= is_read && read_ok;
			if (is_read && read_ok) begin
				load_word_q <= {addr_r, rdata};
			end
		end
	end

	assign link.load = load_q;
	assign link.load_word = load_word_q;

	// Status outputs from flops
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			legacy_mode <= pcrb_pkg::CTRL_RESET[pcrb_pkg::CTRL_MODE_BIT];
			read_enable <= pcrb_pkg::CTRL_RESET[pcrb_pkg::CTRL_RDEN_BIT];
			bank_code <= pcrb_pkg::BANK_RESET[7:0];
			init_key <= pcrb_pkg::KEY_RESET[3:0];
		end else begin
			legacy_mode <= ctrl_q[pcrb_pkg::CTRL_MODE_BIT];
			read_enable <= ctrl_q[pcrb_pkg::CTRL_RDEN_BIT];
			bank_code <= bank_q[7:0];
			init_key <= key_q[3:0];
		end
	end
endmodule

// >>> hdl/pcrb_link_if.sv
// Interface carrying whole serial frames between the shifter and the bank.
// Assumes both ends run on ref_clk.
`timescale 1ns/10ps
interface pcrb_link_if;
	logic frame_done;
	logic [23:0] frame_word;
	logic load;
	logic [23:0] load_word;
	modport shifter (output frame_done, output frame_word, input load, input load_word);
	modport bank (input frame_done, input frame_word, output load, output load_word);
endinterface

// >>> hdl/pcrb_pkg.sv
// Package of the paged configuration register bank: offsets, codes, reset values.
// Assumes a single 100 MHz reference clock domain for all users.
package pcrb_pkg;
	localparam int FRAME_BITS = 24;
	localparam logic [4:0] FRAME_BITS_C = 5'h18;

	// Bank 0 offsets
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_BANK = 8'h03;
	localparam logic [7:0] ADDR_KEY = 8'h04;
	localparam logic [7:0] ADDR_COPY = 8'h06;

	// Bank select codes
	localparam logic [7:0] BANK0_CODE = 8'h00;
	localparam logic [7:0] BANK1_CODE = 8'h02;
	localparam logic [7:0] BANK2_CODE = 8'h10;

	// Frame lead bytes
	localparam logic [7:0] CMD_READ = 8'hfe;
	localparam logic [7:0] CMD_NOP = 8'hff;

	// Control register fields
	localparam int CTRL_RST_BIT = 0;
	localparam int CTRL_RDEN_BIT = 1;
	localparam int CTRL_MODE_BIT = 2;

	// Reset values
	localparam logic [15:0] CTRL_RESET = 16'h0002;
	localparam logic [15:0] BANK_RESET = 16'h0002;
	localparam logic [15:0] KEY_RESET = 16'h0000;
	localparam logic [3:0] KEY_INIT = 4'hb;
	localparam logic [3:0] KEY_NORMAL = 4'h0;

	// Bank 1 map
	localparam int B1_COUNT = 17;
	localparam logic [7:0] B1_OFFS [B1_COUNT] = '{
		8'h0d, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1a,
		8'h1b, 8'h1c, 8'h33, 8'hc0, 8'hc1, 8'hc4, 8'hc5, 8'hf4
	};
	localparam logic [15:0] B1_RESET [B1_COUNT] = '{
		16'h2002, 16'h0002, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000
	};
	// Two bank 1 offsets beyond the array
	localparam logic [7:0] B1_OFF_F6 = 8'hf6;
	localparam logic [7:0] B1_OFF_FB = 8'hfb;
	localparam logic [15:0] B1_RESET_TAIL = 16'h0000;
endpackage

// >>> hdl/pcrb_shifter.sv
// Serial frame shifter: pin synchronisers, 24-bit receive and send shift registers.
// Assumes sclk well below a quarter of ref_clk; cs_n, sclk, sdi are asynchronous pins.
`timescale 1ns/10ps
module pcrb_shifter (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	output logic sdo,
	pcrb_link_if.shifter link
);
	logic [1:0] cs_s_q;
	logic [1:0] clk_s_q;
	logic [1:0] din_s_q;
	logic cs_d_q;
	logic clk_d_q;
	logic [23:0] in_q;
	logic [23:0] out_q;
	logic [4:0] cnt_q;
	logic done_q;
	logic sdo_q;
	logic rise;
	logic fall;
	logic cs_fall;
	logic cs_rise;

	// Two stages before any logic
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			cs_s_q <= 2'h3;
			clk_s_q <= 2'h0;
			din_s_q <= 2'h0;
			cs_d_q <= 1'b1;
			clk_d_q <= 1'b0;
		end else begin
			cs_s_q <= {cs_s_q[0], cs_n};
			clk_s_q <= {clk_s_q[0], sclk};
			din_s_q <= {din_s_q[0], sdi};
			cs_d_q <= cs_s_q[1];
			clk_d_q <= clk_s_q[1];
		end
	end

	assign rise = !cs_s_q[1] && clk_s_q[1] && !clk_d_q;
	assign fall = !cs_s_q[1] && !clk_s_q[1] && clk_d_q;
	assign cs_fall = !cs_s_q[1] && cs_d_q;
	assign cs_rise = cs_s_q[1] && !cs_d_q;

	// Receive side; short frames are dropped
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			in_q <= 24'h00_0000;
			cnt_q <= 5'h00;
			done_q <= 1'b0;
		end else begin
			done_q <= cs_rise && (cnt_q >= pcrb_pkg::FRAME_BITS_C);
			if (cs_fall) begin
				cnt_q <= 5'h00;
			end else if (rise) begin
				in_q <= {in_q[22:0], din_s_q[1]};
				if (cnt_q != 5'h1f) begin
					cnt_q <= cnt_q + 5'h01;
				end
			end
		end
	end

	// Send side shifts the input on, so a chain sees a 24-clock delay
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			out_q <= 24'h00_0000;
			sdo_q <= 1'b0;
		end else begin
			if (link.load) begin
				out_q <= link.load_word;
			end else if (rise) begin
				out_q <= {out_q[22:0], din_s_q[1]};
			end
			if (cs_fall || fall) begin
				sdo_q <= out_q[23];
			end
		end
	end

	assign link.frame_done = done_q;
	assign link.frame_word = in_q;
	assign sdo = sdo_q;
endmodule

// >>> tb/pcrb_bank_checker.sv
// Port checker for the paged register bank.
// Assumes one ref_clk domain; bound to every pcrb_bank.
`timescale 1ns/10ps
module pcrb_bank_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic sdi,
	input wire logic sdo,
	input wire logic legacy_mode,
	input wire logic read_enable,
	input wire logic [7:0] bank_code,
	input wire logic [3:0] init_key
);
	logic [1:0] pin_q;
	logic [3:0] rise_q;
	logic [3:0] edge_q;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Ages since frame end and since last shift edge; saturate at 15
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_q <= 2'b10;
			rise_q <= 4'hf;
			edge_q <= 4'hf;
		end else begin
			pin_q <= {cs_n, sclk};
			rise_q <= (cs_n && !pin_q[1]) ? 4'h0 : rise_q + 4'(rise_q != 4'hf);
			edge_q <= ((pin_q[0] && !sclk) || (pin_q[1] && !cs_n)) ? 4'h0 :
				edge_q + 4'(edge_q != 4'hf);
		end
	end
	chk_reset_state: assert property ($rose(rst_n) |-> sdo == 1'b0 && !legacy_mode &&
		read_enable && bank_code == 8'h02 && init_key == 4'h0) else $error("bad reset state");
	chk_cfg_timing: assert property (($changed(bank_code) || $changed(init_key)) |->
		rise_q >= 4'h2 && rise_q <= 4'hc) else $error("config moved outside frame end");
	chk_mode_timing: assert property (($changed(legacy_mode) || $changed(read_enable)) |->
		rise_q >= 4'h2 && rise_q <= 4'hc) else $error("mode moved outside frame end");
	chk_cfg_settled: assert property (($changed(bank_code) || $changed(init_key)) |=>
		($stable(bank_code) && $stable(init_key))[*8]) else $error("config flickered");
	chk_mode_settled: assert property (($changed(legacy_mode) || $changed(read_enable)) |=>
		$stable({legacy_mode, read_enable})[*8]) else $error("mode flickered");
	chk_idle_stable: assert property ((cs_n[*8] ##1 cs_n[*2]) |=>
		$stable({sdo, legacy_mode, read_enable, bank_code, init_key})) else $error("idle change");
	chk_frame_quiet: assert property ((!cs_n)[*8] |=>
		$stable({legacy_mode, read_enable, bank_code, init_key})) else $error("change in frame");
	chk_sdo_edge: assert property ($changed(sdo) |-> edge_q <= 4'h8)
		else $error("sdo moved without shift edge");
	cover property ($changed(bank_code));
	cover property ($changed(init_key));
	cover property ($fell(read_enable));
endmodule
bind pcrb_bank pcrb_bank_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n),
	.sclk(sclk), .sdi(sdi), .sdo(sdo), .legacy_mode(legacy_mode), .read_enable(read_enable),
	.bank_code(bank_code), .init_key(init_key));

// >>> tb/pcrb_ctrl_model.sv
// Serial configuration controller: one 24-bit frame per call.
// Assumes sdi sampled on sclk rise and sdo shifted on sclk fall.
`timescale 1ns/10ps
module pcrb_ctrl_model (
	input wire logic ref_clk,
	output logic cs_n,
	output logic sclk,
	output logic sdi,
	input wire logic sdo
);
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	// Whole 24-bit frames, MSB first; sclk parked low
	task automatic xfer(input logic [23:0] w, input int half, output logic [23:0] r);
		@(posedge ref_clk) cs_n <= 1'b0;
		for (int i = 23; i >= 0; i--) begin
			sdi <= w[i];
			repeat (half) @(posedge ref_clk);
			sclk <= 1'b1;
			r[i] = sdo;
			repeat (half) @(posedge ref_clk);
			sclk <= 1'b0;
		end
		repeat (4) @(posedge ref_clk);
		cs_n <= 1'b1;
		// Released line shows the inverse, never a stale bit
		sdi <= ~sdi;
		// Idle gap above the ten-cycle minimum
		repeat (12) @(posedge ref_clk);
	endtask
endmodule

// >>> tb/tb.sv
// Self-checking bench: scripted and random frames against a register model.
// Assumes the controller model and the bound port checker.
`timescale 1ns/10ps
module tb;
	logic ref_clk;
	logic rst_n;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic sdo;
	logic legacy_mode;
	logic read_enable;
	logic [7:0] bank_code;
	logic [3:0] init_key;
	int n_mismatch;
	int comparisons;
	int seed;
	int k;
	logic [15:0] d;
	logic [15:0] ctrl;
	logic [15:0] bank;
	logic [15:0] key;
	logic [15:0] b1 [int];
	logic [23:0] exp_w;
	logic [23:0] script [$];
	logic [7:0] sel [4] = '{8'h00, 8'h02, 8'h10, 8'h5c};
	logic [7:0] offs [4] = '{8'h14, 8'h16, 8'h19, 8'h1b};
	pcrb_bank dut (.ref_clk(ref_clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .sdi(sdi),
		.sdo(sdo), .legacy_mode(legacy_mode), .read_enable(read_enable),
		.bank_code(bank_code), .init_key(init_key));
	pcrb_ctrl_model ctl (.ref_clk(ref_clk), .cs_n(cs_n), .sclk(sclk), .sdi(sdi), .sdo(sdo));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task automatic chk_word(input logic [23:0] g, input logic [23:0] e);
		comparisons++;
		if (g !== e) begin
			n_mismatch++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic chk_port(input logic [13:0] g, input logic [13:0] e);
		chk_word({10'h000, g}, {10'h000, e});
	endtask
	task automatic mdl_reset();
		ctrl = pcrb_pkg::CTRL_RESET;
		bank = pcrb_pkg::BANK_RESET;
		key = pcrb_pkg::KEY_RESET;
		for (int i = 0; i < pcrb_pkg::B1_COUNT; i++) b1[pcrb_pkg::B1_OFFS[i]] = pcrb_pkg::B1_RESET[i];
		b1[8'hf6] = pcrb_pkg::B1_RESET_TAIL;
		b1[8'hfb] = pcrb_pkg::B1_RESET_TAIL;
	endtask
	function automatic logic [15:0] rd(input logic [7:0] a);
		if (a == 8'h03) return bank;
		if (bank[7:0] == 8'h00 && a == 8'h04) return key;
		if (bank[7:0] == 8'h00 && a == 8'h06) return ctrl;
		if (bank[7:0] == 8'h02 && b1.exists(a)) return b1[a];
		return 16'h0000;
	endfunction
	task automatic frame(input logic [23:0] w);
		logic [23:0] r;
		ctl.xfer(w, 5 + ($random(seed) & 3), r);
		chk_word(r, exp_w);
		exp_w = w;
		if (w[23:16] == 8'hfe) begin
			if (!(ctrl[2] && !ctrl[1])) exp_w = {w[7:0], rd(w[7:0])};
		end else if (w[23:16] == 8'h03) bank = w[15:0];
		else if (w[23:16] == 8'h00) begin
			ctrl = w[15:0];
			if (w[0]) mdl_reset();
		end else if (bank[7:0] == 8'h00 && w[23:16] == 8'h04) key = w[15:0];
		else if (bank[7:0] == 8'h02 && b1.exists(w[23:16])) b1[w[23:16]] = w[15:0];
		chk_port({legacy_mode, read_enable, bank_code, init_key},
			{ctrl[2], ctrl[1], bank[7:0], key[3:0]});
	endtask
	task automatic wrap_up();
		$display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		repeat (90000) @(posedge ref_clk);
		n_mismatch++;
		wrap_up();
	end
	initial begin
		seed = 21357;
		n_mismatch = 0;
		comparisons = 0;
		rst_n = 1'b0;
		exp_w = 24'h00_0000;
		mdl_reset();
		repeat (4) @(posedge ref_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge ref_clk);
		// Banks, isolation, key, copy, read enable, soft reset
		script = '{24'hfe_000d, 24'h14_5a5a, 24'hfe_0014, 24'h03_0010, 24'h14_1234,
			24'hfe_0014, 24'h03_0000, 24'hfe_0006, 24'hfe_0000, 24'h04_000b, 24'hfe_0004,
			24'h04_0000, 24'h06_ffff, 24'h00_0006, 24'hfe_0006, 24'h00_0004, 24'hfe_0006,
			24'h00_0000, 24'hfe_0004, 24'h03_0002, 24'hfe_0014, 24'h00_0001, 24'hff_ffff};
		foreach (script[i]) frame(script[i]);
		$display("scripted frames done");
		for (int n = 0; n < 60; n++) begin
			k = $random(seed) & 7;
			d = 16'($random(seed));
			// Reserved bits held at zero in bank select, key and control writes; bank 1 writes carry all 16 random bits
			case (k)
				0: frame({16'h0300, sel[d[1:0]]});
				1: frame({8'h04, 12'h000, (d[0] ? pcrb_pkg::KEY_INIT : pcrb_pkg::KEY_NORMAL)});
				2: frame({8'h00, 13'h0000, d[2:1], 1'b0});
				3: frame({offs[d[1:0]], d});
				4: frame({16'hfe00, 5'h00, d[2:0]});
				default: frame({16'hfe00, d[15] ? d[7:0] : offs[d[1:0]]});
			endcase
		end
		$display("random frames done");
		wrap_up();
	end
endmodule
